// [hw/wkr_regs_map.vh]
// Register map constants for the wake-up receiver configuration bank.
// Assumes registers are reached by a six-bit index from the serial command decoder.
//
// What this block does
// (RULE1) Hysteresis select bit: 0 gives 40mV, 1 gives 20mV; resets to zero.
// (RULE2) Hysteresis edge bit: 0 both edges, 1 rising only; resets to zero.
// (RULE3) Register 3 holds slicer constant bits 5:3 reset 100, envelope bits 2:0 reset 000.
// (RULE4) Two-bit off time picks 1, 2, 4 or 8 ms; resets to 00.
// (RULE5) Register 4 bits 5:4 select antenna damping resistor; reset 01.
// (RULE6) Register 4 bits 3:0 hold gain reduction; reset 0000.
// (RULE7) Registers 5 and 6 hold pattern bytes two and one, reset 69 and 96.
// (RULE8) Register 7 holds timeout bits 7:5 reset 000, bit rate bits 4:0 reset 01011.
// (RULE9) Artificial wake-up code 000 disables; 001 to 111 pick 1s up to 2h.
// (RULE10) Register 16 bit 7 routes clock generator onto clock/data pin; reset zero.
// (RULE11) Register 16 bits 5 and 4 force oscillator slowest or fastest; reset zero.
// (RULE12) Register 16 bits 2, 1, 0 show channel 3, 2, 1 resonance on data pin.
// (RULE13) Registers 17 to 19 hold five-bit tuning capacitor settings, reset zero.
// (RULE14) Commands carry a six-bit register address in bits 13 to 8.
// (RULE15) The false-wake clear command sets the false wake counter to zero.
// (RULE16) Strength, false wake count, trim and tank status are read-only.
// (RULE17) Register 9 bit 7 disables gain control; bits 6:0 read zero.
`ifndef WKR_REGS_MAP_VH
`define WKR_REGS_MAP_VH

// Register indices.
`define WKR_IDX_SLICER 6'h03
`define WKR_IDX_OFFDAMP 6'h04
`define WKR_IDX_PAT2 6'h05
`define WKR_IDX_PAT1 6'h06
`define WKR_IDX_TOBR 6'h07
`define WKR_IDX_BAND 6'h08
`define WKR_IDX_AGC 6'h09
`define WKR_IDX_STR1 6'h0a
`define WKR_IDX_STR2 6'h0b
`define WKR_IDX_STR3 6'h0c
`define WKR_IDX_FWAKE 6'h0d
`define WKR_IDX_RCCAL 6'h0e
`define WKR_IDX_LCOSC 6'h0f
`define WKR_IDX_OSCTEST 6'h10
`define WKR_IDX_CAP1 6'h11
`define WKR_IDX_CAP2 6'h12
`define WKR_IDX_CAP3 6'h13

// Reset values.
`define WKR_RST_SLICER 8'h20
`define WKR_RST_OFFDAMP 8'h10
`define WKR_RST_PAT2 8'h69
`define WKR_RST_PAT1 8'h96
`define WKR_RST_TOBR 8'h0b
`define WKR_RST_BAND 8'h00
`define WKR_RST_AGC 8'h00
`define WKR_RST_OSCTEST 8'h00
`define WKR_RST_CAP 8'h00

// Writable bit masks.
`define WKR_MASK_AGC 8'h80
`define WKR_MASK_OSCTEST 8'hb7
`define WKR_MASK_CAP 8'h1f

// Direct command code for clearing the false wake counter.
`define WKR_CMD_CLEAR_FALSE 6'h03

`endif

// [hw/wkr_regs.v]
// Configuration and status register bank of a three-channel wake-up receiver.
// Assumes a serial command decoder presents one-cycle write, read and command strobes.
`timescale 1ns/1ps
`default_nettype none
`include "wkr_regs_map.vh"

module wkr_regs (
   // Clock and reset.
   input wire clk_in,
   input wire reset_in,
   // Command port from the serial decoder.
   input wire [5:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   input wire cmd_in,
   input wire preset_in,
   output reg [7:0] rdata_out,
   output reg rvalid_out,
   // Status from the receiver.
   input wire [4:0] strength_level_ch1_in,
   input wire [4:0] strength_level_ch2_in,
   input wire [4:0] strength_level_ch3_in,
   input wire false_wake_in,
   input wire rc_trim_pass_in,
   input wire rc_trim_fail_in,
   input wire [5:0] rc_trim_taps_in,
   input wire tank_osc_running_in,
   input wire tank_osc_failed_in,
   // Control outputs to the receiver.
   output wire slicer_hyst_small_out,
   output wire hyst_rising_only_out,
   output wire [2:0] slicer_time_const_out,
   output wire [2:0] envelope_time_const_out,
   output wire [1:0] off_time_out,
   output wire [1:0] antenna_damping_sel_out,
   output wire [3:0] gain_reduction_out,
   output wire [7:0] pattern_second_byte_out,
   output wire [7:0] pattern_first_byte_out,
   output wire [2:0] timeout_out,
   output wire [4:0] bit_rate_setting_out,
   output wire [2:0] band_sel_out,
   output wire [2:0] forced_wake_code_out,
   output wire forced_wake_enable_out,
   output wire gain_control_disable_out,
   output wire clkgen_to_output_pin_out,
   output wire rc_force_slowest_out,
   output wire rc_force_fastest_out,
   output wire [2:0] show_resonance_out,
   output wire [14:0] tuning_cap_bank_out
);

   reg [7:0] slicer_r;
   reg [7:0] offdamp_r;
   reg [7:0] pat2_r;
   reg [7:0] pat1_r;
   reg [7:0] tobr_r;
   reg [7:0] band_r;
   reg [7:0] agc_r;
   reg [7:0] osctest_r;
   reg [7:0] fwake_r;
   reg [7:0] rdata_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Writable configuration registers; a preset reloads every default.
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         slicer_r <= `WKR_RST_SLICER; // RULE1 RULE2 RULE3
         offdamp_r <= `WKR_RST_OFFDAMP; // RULE4 RULE5 RULE6
         pat2_r <= `WKR_RST_PAT2; // RULE7
         pat1_r <= `WKR_RST_PAT1;
         tobr_r <= `WKR_RST_TOBR; // RULE8
         band_r <= `WKR_RST_BAND;
         agc_r <= `WKR_RST_AGC;
         osctest_r <= `WKR_RST_OSCTEST;
      end else if (preset_in) begin
         slicer_r <= `WKR_RST_SLICER;
         offdamp_r <= `WKR_RST_OFFDAMP;
         pat2_r <= `WKR_RST_PAT2;
         pat1_r <= `WKR_RST_PAT1;
         tobr_r <= `WKR_RST_TOBR;
         band_r <= `WKR_RST_BAND;
         agc_r <= `WKR_RST_AGC;
         osctest_r <= `WKR_RST_OSCTEST;
      end else if (wr_in) begin
         // Address decode; read-only indices fall through untouched.
         if (addr_in == `WKR_IDX_SLICER) begin // RULE14
            slicer_r <= wdata_in;
         end else if (addr_in == `WKR_IDX_OFFDAMP) begin
            offdamp_r <= wdata_in;
         end else if (addr_in == `WKR_IDX_PAT2) begin
            pat2_r <= wdata_in;
         end else if (addr_in == `WKR_IDX_PAT1) begin
            pat1_r <= wdata_in;
         end else if (addr_in == `WKR_IDX_TOBR) begin
            tobr_r <= wdata_in;
         end else if (addr_in == `WKR_IDX_BAND) begin
            band_r <= wdata_in;
         end else if (addr_in == `WKR_IDX_AGC) begin
            agc_r <= wdata_in & `WKR_MASK_AGC; // RULE17
         end else if (addr_in == `WKR_IDX_OSCTEST) begin
            osctest_r <= wdata_in & `WKR_MASK_OSCTEST; // RULE10 RULE11 RULE12
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One tuning capacitor register per channel, each owned by its own process.
   genvar ch;
   generate
      for (ch = 0; ch < 3; ch = ch + 1) begin : g_cap
         // Index of this channel's register, cut to the address width on purpose.
         localparam [31:0] CAP_IDX = {26'h0000000, `WKR_IDX_CAP1} + ch;
         reg [7:0] cap_r;
         always @(posedge clk_in or posedge reset_in) begin
            if (reset_in) begin
               cap_r <= `WKR_RST_CAP;
            end else if (preset_in) begin
               cap_r <= `WKR_RST_CAP;
            end else if (wr_in && (addr_in == CAP_IDX[5:0])) begin
               cap_r <= wdata_in & `WKR_MASK_CAP; // RULE13
            end
         end
         assign tuning_cap_bank_out[5*ch+4:5*ch] = cap_r[4:0];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // False wake counter: saturates, clear command wins over a false wake.
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         fwake_r <= 8'h00;
      end else if (cmd_in && (addr_in == `WKR_CMD_CLEAR_FALSE)) begin
         fwake_r <= 8'h00; // RULE15
      end else if (false_wake_in && (fwake_r != 8'hff)) begin
         fwake_r <= fwake_r + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer; status views ignore writes, unmapped reads give zero.
   always @* begin
      rdata_nxt = 8'h00;
      if (addr_in == `WKR_IDX_SLICER) begin
         rdata_nxt = slicer_r;
      end else if (addr_in == `WKR_IDX_OFFDAMP) begin
         rdata_nxt = offdamp_r;
      end else if (addr_in == `WKR_IDX_PAT2) begin
         rdata_nxt = pat2_r;
      end else if (addr_in == `WKR_IDX_PAT1) begin
         rdata_nxt = pat1_r;
      end else if (addr_in == `WKR_IDX_TOBR) begin
         rdata_nxt = tobr_r;
      end else if (addr_in == `WKR_IDX_BAND) begin
         rdata_nxt = band_r;
      end else if (addr_in == `WKR_IDX_AGC) begin
         rdata_nxt = agc_r;
      end else if (addr_in == `WKR_IDX_STR1) begin
         rdata_nxt = {3'h0, strength_level_ch1_in}; // RULE16
      end else if (addr_in == `WKR_IDX_STR2) begin
         rdata_nxt = {3'h0, strength_level_ch2_in};
      end else if (addr_in == `WKR_IDX_STR3) begin
         rdata_nxt = {3'h0, strength_level_ch3_in};
      end else if (addr_in == `WKR_IDX_FWAKE) begin
         rdata_nxt = fwake_r;
      end else if (addr_in == `WKR_IDX_RCCAL) begin
         rdata_nxt = {rc_trim_pass_in, rc_trim_fail_in, rc_trim_taps_in};
      end else if (addr_in == `WKR_IDX_LCOSC) begin
         rdata_nxt = {3'h0, tank_osc_running_in, tank_osc_failed_in, 3'h0};
      end else if (addr_in == `WKR_IDX_OSCTEST) begin
         rdata_nxt = osctest_r;
      end else if (addr_in == `WKR_IDX_CAP1) begin
         rdata_nxt = {3'h0, tuning_cap_bank_out[4:0]};
      end else if (addr_in == `WKR_IDX_CAP2) begin
         rdata_nxt = {3'h0, tuning_cap_bank_out[9:5]};
      end else if (addr_in == `WKR_IDX_CAP3) begin
         rdata_nxt = {3'h0, tuning_cap_bank_out[14:10]};
      end
   end

   // Read data registered one cycle after the read strobe.
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         rdata_out <= 8'h00;
         rvalid_out <= 1'b0;
      end else begin
         rvalid_out <= rd_in;
         if (rd_in) begin
            rdata_out <= rdata_nxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Field outputs to the analog and timing logic.
   assign slicer_hyst_small_out = slicer_r[7]; // RULE1
   assign hyst_rising_only_out = slicer_r[6]; // RULE2
   assign slicer_time_const_out = slicer_r[5:3]; // RULE3
   assign envelope_time_const_out = slicer_r[2:0];
   assign off_time_out = offdamp_r[7:6]; // RULE4
   assign antenna_damping_sel_out = offdamp_r[5:4]; // RULE5
   assign gain_reduction_out = offdamp_r[3:0]; // RULE6
   assign pattern_second_byte_out = pat2_r; // RULE7
   assign pattern_first_byte_out = pat1_r;
   assign timeout_out = tobr_r[7:5]; // RULE8
   assign bit_rate_setting_out = tobr_r[4:0];
   assign band_sel_out = band_r[7:5];
   assign forced_wake_code_out = band_r[2:0]; // RULE9
   assign forced_wake_enable_out = (band_r[2:0] != 3'h0); // RULE9
   assign gain_control_disable_out = agc_r[7]; // RULE17
   assign clkgen_to_output_pin_out = osctest_r[7]; // RULE10
   assign rc_force_slowest_out = osctest_r[5]; // RULE11
   assign rc_force_fastest_out = osctest_r[4];
   assign show_resonance_out = osctest_r[2:0]; // RULE12

endmodule
`default_nettype wire

// [verification/wkr_regs_checker.sv]
// Concurrent checks for the register bank, bound to wkr_regs.
// Assumes only the bank's own ports are visible.
`timescale 1ns/1ps
`default_nettype none
module wkr_regs_checker (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic reset_in,
   // Command port.
   input wire logic [5:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic preset_in,
   input wire logic [7:0] rdata_out,
   input wire logic rvalid_out,
   // Controls.
   input wire logic [7:0] pattern_second_byte_out,
   input wire logic gain_control_disable_out,
   input wire logic [14:0] tuning_cap_bank_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // A write strobe at one index with no preset beside it.
   sequence s_wr(a);
      wr_in && !preset_in && addr_in == a;
   endsequence
   // Read answers, writes, presets and holds.
   a_read_valid: assert property (rd_in |=> rvalid_out) else $error("no rvalid");
   a_valid_alone: assert property (!rd_in |=> !rvalid_out) else $error("stray rvalid");
   a_read_hold: assert property (!rd_in |=> $stable(rdata_out)) else $error("rdata moved");
   a_agc_zero: assert property (
      rd_in && addr_in == 6'h09 |=> rdata_out[6:0] == 7'h00) else $error("agc spare set");
   a_pat_write: assert property (
      s_wr(6'h05) |=> pattern_second_byte_out == $past(wdata_in)) else $error("pattern lost");
   a_pat_preset: assert property (
      preset_in |=> pattern_second_byte_out == 8'h69) else $error("pattern not preset");
   a_agc_write: assert property (
      s_wr(6'h09) |=> gain_control_disable_out == $past(wdata_in[7])) else $error("agc lost");
   a_caps_hold: assert property (
      !wr_in && !preset_in |=> $stable(tuning_cap_bank_out)) else $error("caps moved");
   a_cap1_write: assert property (
      s_wr(6'h11) |=> tuning_cap_bank_out[4:0] == $past(wdata_in[4:0])) else $error("cap lost");
endmodule
`default_nettype wire

// [verification/wkr_host.sv]
// Host model: issues the one-cycle strobes of the serial command decoder.
// Assumes the bench calls pulse; operands change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module wkr_host (
   // Clock.
   input wire logic clk_in,
   // Strobes and operands.
   output var logic [5:0] addr_out,
   output var logic [7:0] wdata_out,
   output var logic wr_out,
   output var logic rd_out,
   output var logic cmd_out,
   output var logic preset_out
);
   // Idle at time zero.
   initial begin
      {addr_out, wdata_out, wr_out, rd_out, cmd_out, preset_out} = 18'h00000;
   end
   // Kind 0 write, 1 read, 2 command, 3 preset; idle operands are scrambled.
   task automatic pulse(input int k, input logic [5:0] a, input logic [7:0] d);
      @(negedge clk_in);
      addr_out = a;
      wdata_out = d;
      {wr_out, rd_out, cmd_out, preset_out} = 4'h8 >> k;
      @(negedge clk_in);
      {wr_out, rd_out, cmd_out, preset_out} = 4'h0;
      addr_out = ~a;
      wdata_out = ~d;
   endtask
endmodule
`default_nettype wire

// [verification/wkr_regs_bench.sv]
// Self-checking bench for the wake-up receiver register bank.
// Assumes wkr_host makes the strobes; the checker is bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module wkr_regs_bench;
   logic clk_in = 1'b0, reset_in = 1'b1, fw = 1'b0, wr, rd, cmd, pre;
   logic [5:0] addr;
   logic [7:0] wdata, rdata;
   logic [4:0] s1 = 5'h15, s2 = 5'h0a, s3 = 5'h1f, br;
   logic [5:0] tp = 6'h2d;
   logic pa = 1'b1, fa = 1'b0, ru = 1'b1, fl = 1'b0;
   logic hys, hro, fwe, gcd, ckp, rsl, rfa, rvalid;
   logic [2:0] stc, fwc, shr, env, tmo, bsl;
   logic [3:0] gr;
   logic [7:0] p2, p1;
   logic [1:0] off, dmp;
   logic [14:0] cap;
   int fail_count = 0, num_checks = 0, cyc = 0;
   wkr_host h (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
      .rd_out(rd), .cmd_out(cmd), .preset_out(pre));
   wkr_regs DUT (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .cmd_in(cmd), .preset_in(pre), .rdata_out(rdata),
      .rvalid_out(rvalid),
      .strength_level_ch1_in(s1), .strength_level_ch2_in(s2), .strength_level_ch3_in(s3),
      .false_wake_in(fw), .rc_trim_pass_in(pa), .rc_trim_fail_in(fa), .rc_trim_taps_in(tp),
      .tank_osc_running_in(ru), .tank_osc_failed_in(fl), .slicer_hyst_small_out(hys),
      .hyst_rising_only_out(hro), .slicer_time_const_out(stc), .envelope_time_const_out(env),
      .off_time_out(off), .antenna_damping_sel_out(dmp), .gain_reduction_out(gr),
      .pattern_second_byte_out(p2), .pattern_first_byte_out(p1), .timeout_out(tmo),
      .bit_rate_setting_out(br), .band_sel_out(bsl), .forced_wake_code_out(fwc),
      .forced_wake_enable_out(fwe), .gain_control_disable_out(gcd),
      .clkgen_to_output_pin_out(ckp), .rc_force_slowest_out(rsl), .rc_force_fastest_out(rfa),
      .show_resonance_out(shr), .tuning_cap_bank_out(cap));
   // Clock and a hang guard.
   always #5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 2000) begin
         fail_count++;
         end_sim();
      end
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rdc(input logic [5:0] a, input logic [7:0] e);
      h.pulse(1, a, 8'h00);
      chk({rvalid, rdata}, {1'b1, e});
   endtask
   // Status registers mirror the inputs, the false wake count (13) gives zero; others give t.
   function automatic logic [7:0] ev(int i, logic [7:0] t);
      case (i)
         10: ev = {3'h0, s1};
         11: ev = {3'h0, s2};
         12: ev = {3'h0, s3};
         13: ev = 8'h00;
         14: ev = {pa, fa, tp};
         15: ev = {3'h0, ru, fl, 3'h0};
         default: ev = t;
      endcase
   endfunction
   task automatic t_reset;
      logic [7:0] rv [3:9] = '{8'h20, 8'h10, 8'h69, 8'h96, 8'h0b, 8'h00, 8'h00};
      for (int i = 3; i < 20; i++) rdc(6'(i), ev(i, i < 10 ? rv[i] : 8'h00));
      chk({stc, dmp, br}, 10'h22b);
      chk({hys, hro, off, ckp, rsl, rfa, shr, gcd}, 11'h000);
      chk({env, gr, tmo}, 10'h000);
      chk({p2, p1}, 16'h6996);
      chk(cap, 15'h0000);
   endtask
   task automatic t_write;
      {s1, s2, s3, tp, pa, fa, ru, fl} = ~{s1, s2, s3, tp, pa, fa, ru, fl};
      for (int i = 2; i < 21; i++) h.pulse(0, 6'(i), 8'hff);
      for (int i = 3; i < 20; i++) if (i != 8) rdc(6'(i), ev(i, i == 9 ? 8'h80 :
         i == 16 ? 8'hb7 : i > 16 ? 8'h1f : 8'hff));
      rdc(6'h14, 8'h00);
      chk({hys, hro, ckp, rsl, rfa, shr, gcd}, 9'h1ff);
      chk({env, gr, tmo}, 10'h3ff);
      chk({p2, p1}, 16'hffff);
      chk(cap, 15'h7fff);
      h.pulse(0, 6'h10, 8'h01);
      chk(shr, 3'h1);
   endtask
   task automatic t_codes;
      for (int c = 0; c < 8; c++) begin
         h.pulse(0, 6'h08, {3'(c), 2'h0, 3'(c)});
         chk({bsl, fwc, fwe}, {3'(c), 3'(c), c != 0});
         h.pulse(0, 6'h04, {2'(c), 2'h1, 4'(c)});
         chk({off, dmp, gr}, {2'(c), 2'h1, 4'(c)});
      end
   endtask
   task automatic t_false;
      repeat (3) begin
         @(negedge clk_in) fw = 1'b1;
         @(negedge clk_in) fw = 1'b0;
      end
      h.pulse(2, 6'h01, 8'h00);
      rdc(6'h0d, 8'h03);
      h.pulse(2, 6'h03, 8'h00);
      rdc(6'h0d, 8'h00);
      h.pulse(3, 6'h00, 8'h00);
      rdc(6'h06, 8'h96);
      // A reset in mid-run must zero the counter and reload the pattern.
      h.pulse(0, 6'h05, 8'h5a);
      @(negedge clk_in) fw = 1'b1;
      @(negedge clk_in) fw = 1'b0;
      reset_in = 1'b1;
      repeat (2) @(negedge clk_in);
      reset_in = 1'b0;
      rdc(6'h0d, 8'h00);
      rdc(6'h05, 8'h69);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Reset for six cycles, then run each scenario.
   initial begin
      repeat (6) @(negedge clk_in);
      reset_in = 1'b0;
      t_reset();
      t_write();
      t_codes();
      t_false();
      end_sim();
   end
endmodule
bind wkr_regs wkr_regs_checker u_chk (.*);
`default_nettype wire
